// >>> test/rwc_host_model.sv
`default_nettype none

module rwc_host_model (
  // serial link toward the device
  output var logic sck_out,
  output var logic cs_n_out,
  output var logic io0_out,
  output var logic io4_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b0;
    io0_out = 1'b0;
    io4_out = 1'b1;
    // a clean rising edge clears the link's frame flag before any frame
    #1 cs_n_out = 1'b1;
  end

  // mode 0: clock stands low between frames, 12 ns bit period
  task automatic xfer(input logic [23:0] d0, input logic [23:0] d1, input int n);
    #5;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      io0_out = d0[23-i];
      io4_out = d1[23-i];
      #6 sck_out = 1'b1;
      #6 sck_out = 1'b0;
    end
    #6 cs_n_out = 1'b1;
    // released lines must not keep the last bit
    io0_out = ~io0_out;
    io4_out = ~io4_out;
    #20;
  endtask : xfer
endmodule : rwc_host_model

`default_nettype wire

// >>> test/test_register_write_commands.sv
`default_nettype none

module test_register_write_commands;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock_in;
  logic nrst_in;
  logic sck, cs_n, io0, io4;
  logic wp_n_in;
  logic embedded_busy_in;
  logic [1:0] update_fail_in;
  logic [rwc_pkg::LANES-1:0][7:0] sr1, cr, bank;
  logic [rwc_pkg::LANES-1:0][rwc_pkg::BANK_LO_W-1:0] addr_hi;
  logic busy, armed;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  // short update keeps the run brief
  rwc_core #(.UPDATE_CYCLES(8)) dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .sck_in(sck), .cs_n_in(cs_n),
    .io0_in(io0), .io4_in(io4), .wp_n_in(wp_n_in), .embedded_busy_in(embedded_busy_in),
    .update_fail_in(update_fail_in), .sr1_out(sr1), .cr_out(cr), .bank_out(bank),
    .addr_hi_out(addr_hi), .update_busy_out(busy), .bank_armed_out(armed)
  );

  rwc_host_model host (.sck_out(sck), .cs_n_out(cs_n), .io0_out(io0), .io4_out(io4));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_clk

  // decode lands 2-3 cycles after chip select rises
  task automatic send(input logic [7:0] c, input logic [15:0] l0, input logic [15:0] l1,
                      input int n, input int w);
    host.xfer({c, l0}, {c, l1}, n);
    wait_clk(w);
  endtask : send

  task automatic op(input logic [7:0] c, input int n);
    send(c, 16'h0000, 16'h0000, n, 8);
  endtask : op

  task automatic chk_sr1(input logic [7:0] e0, input logic [7:0] e1);
    chk8(sr1[0], e0);
    chk8(sr1[1], e1);
  endtask : chk_sr1

  task automatic t_latch();
    op(8'h04, 8);
    chk_sr1(8'h00, 8'h00);
    op(8'h06, 7);
    chk_sr1(8'h00, 8'h00);
    op(8'h06, 8);
    chk_sr1(8'h02, 8'h02);
    op(8'h04, 9);
    chk_sr1(8'h02, 8'h02);
    op(8'h04, 8);
    chk_sr1(8'h00, 8'h00);
  endtask : t_latch

  task automatic t_wrr();
    send(8'h01, 16'h1C02, 16'h0402, 24, 20);
    chk_sr1(8'h00, 8'h00);
    op(8'h06, 8);
    send(8'h01, 16'h1C02, 16'h0402, 24, 2);
    chk1(busy, 1'b1);
    chk_sr1(8'h1F, 8'h07);
    wait_clk(12);
    chk1(busy, 1'b0);
    chk_sr1(8'h1C, 8'h04);
    chk8(cr[0], 8'h02);
    chk8(cr[1], 8'h02);
  endtask : t_wrr

  task automatic t_quad();
    op(8'h06, 8);
    send(8'h01, 16'h0000, 16'h0000, 16, 20);
    chk_sr1(8'h1E, 8'h06);
    send(8'h01, 16'h0000, 16'h0000, 20, 20);
    chk_sr1(8'h1E, 8'h06);
    send(8'h01, 16'h0000, 16'h0000, 24, 20);
    chk8(cr[0], 8'h00);
    op(8'h06, 8);
    send(8'h01, 16'h0C00, 16'h0800, 16, 20);
    chk_sr1(8'h0C, 8'h08);
    chk8(cr[1], 8'h00);
  endtask : t_quad

  task automatic t_fail();
    op(8'h06, 8);
    update_fail_in = 2'b11;
    send(8'h01, 16'h0C00, 16'h0800, 24, 20);
    update_fail_in = 2'b00;
    chk_sr1(8'h6D, 8'h69);
    embedded_busy_in = 1'b1;
    op(8'h06, 8);
    op(8'h04, 8);
    chk_sr1(8'h6F, 8'h6B);
    op(8'h30, 8);
    chk_sr1(8'h0F, 8'h0B);
    embedded_busy_in = 1'b0;
    op(8'h04, 8);
    chk_sr1(8'h0C, 8'h08);
  endtask : t_fail

  task automatic t_bank();
    op(8'hB9, 7);
    chk1(armed, 1'b0);
    op(8'hB9, 8);
    chk1(armed, 1'b1);
    send(8'h01, 16'hFFFF, 16'h02FF, 24, 2);
    chk1(busy, 1'b0);
    chk1(armed, 1'b0);
    chk8(bank[0], 8'h03);
    chk8(bank[1], 8'h02);
    chk8(cr[0], 8'h00);
    chk8({6'h00, addr_hi[0]}, 8'h03);
    chk8({6'h00, addr_hi[1]}, 8'h02);
    chk_sr1(8'h0C, 8'h08);
    op(8'hB9, 8);
    op(8'h00, 3);
    chk1(armed, 1'b0);
    op(8'hB9, 8);
    op(8'h06, 8);
    chk1(armed, 1'b0);
    chk_sr1(8'h0E, 8'h0A);
    send(8'h01, 16'h0C00, 16'h0800, 16, 20);
    chk8(bank[0], 8'h03);
    chk_sr1(8'h0C, 8'h08);
  endtask : t_bank

  task automatic t_prot();
    op(8'h06, 8);
    send(8'h01, 16'h8C00, 16'h8800, 16, 20);
    chk_sr1(8'h8C, 8'h88);
    wp_n_in = 1'b0;
    op(8'h06, 8);
    send(8'h01, 16'h0000, 16'h0000, 16, 20);
    chk_sr1(8'h8E, 8'h8A);
    wp_n_in = 1'b1;
    send(8'h01, 16'h0C00, 16'h0800, 16, 20);
    chk_sr1(8'h0C, 8'h08);
  endtask : t_prot

  initial begin
    nrst_in = 1'b0;
    wp_n_in = 1'b1;
    embedded_busy_in = 1'b0;
    update_fail_in = 2'b00;
    wait_clk(12);
    nrst_in = 1'b1;
    wait_clk(4);
    chk_sr1(8'h00, 8'h00);
    t_latch();
    t_wrr();
    t_quad();
    t_fail();
    t_bank();
    t_prot();
    finish_test();
  end
endmodule : test_register_write_commands

`default_nettype wire

// >>> verilog/rwc_core.sv
// How it works
// - after bank access, write registers loads bank
// - bank pair needs no write enable latch
// - only first data byte bits 1:0 loaded
// - pair closes access, extended select bit kept
// - other command or frame closes bank access
// - write registers needs write enable latch set
// - bits shift in on io0 and io4
// - failed update sets program or erase fail
// - chip select after 8 or 16 data bits
// - self-timed update, busy shown, latch cleared after
// - protect and block bits writable when unprotected
// - write enable sets latch at bit one
// - write enable only on exact eight bits
// - write disable clears write enable latch
// - write disable ignored during embedded operation
// - write disable only on exact eight bits
// - clear status clears both fail flags
// - clear status accepted while busy, latch kept
// - bank supplies high bits when extension off
`default_nettype none

module rwc_core #(
  parameter int UPDATE_CYCLES = rwc_pkg::UPDATE_CYCLES
) (
  // system
  input wire logic clock_in,
  input wire logic nrst_in,
  // serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic io0_in,
  input wire logic io4_in,
  input wire logic wp_n_in,
  // device state, same clock
  input wire logic embedded_busy_in,
  input wire logic [1:0] update_fail_in,
  // register contents
  output logic [rwc_pkg::LANES-1:0][7:0] sr1_out,
  output logic [rwc_pkg::LANES-1:0][7:0] cr_out,
  output logic [rwc_pkg::LANES-1:0][7:0] bank_out,
  output logic [rwc_pkg::LANES-1:0][rwc_pkg::BANK_LO_W-1:0] addr_hi_out,
  output logic update_busy_out,
  output logic bank_armed_out
);

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic wp_meta;
    logic wp_sync;
    logic armed;
    logic busy;
    logic [rwc_pkg::TMR_W-1:0] cnt;
    logic [rwc_pkg::LANES-1:0][7:0] sr1;
    logic [rwc_pkg::LANES-1:0][7:0] cr;
    logic [rwc_pkg::LANES-1:0][7:0] bank;
    logic [rwc_pkg::LANES-1:0][rwc_pkg::BANK_LO_W-1:0] addr_hi;
  } rwc_core_s;

  localparam rwc_core_s CORE_RST = '{
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    cs_prev: 1'b1,
    wp_meta: 1'b1,
    wp_sync: 1'b1,
    armed: 1'b0,
    busy: 1'b0,
    cnt: '0,
    sr1: {rwc_pkg::LANES{rwc_pkg::SR1_RST}},
    cr: {rwc_pkg::LANES{rwc_pkg::CR_RST}},
    bank: {rwc_pkg::LANES{rwc_pkg::BANK_RST}},
    addr_hi: '0
  };

  localparam logic [rwc_pkg::TMR_W-1:0] UPD_LOAD = rwc_pkg::TMR_W'(UPDATE_CYCLES);

  rwc_core_s r;
  rwc_core_s nxt;
  rwc_pkg::rwc_frame_s frm;

  // instruction lands in [23:16], first data byte [15:8], second [7:0]
  function automatic logic [rwc_pkg::SHIFT_W-1:0] align_frame(
    input logic [rwc_pkg::SHIFT_W-1:0] sh,
    input logic [rwc_pkg::CNT_W-1:0] bits
  );
    logic [rwc_pkg::SHIFT_W-1:0] a;
    a = '0;
    unique case (bits)
      rwc_pkg::BITS_INSTR: a = {sh[7:0], 16'h0000};
      rwc_pkg::BITS_ONE: a = {sh[15:0], 8'h00};
      rwc_pkg::BITS_TWO: a = sh;
      default: a = '0;
    endcase
    return a;
  endfunction : align_frame

  rwc_link_rx u_link (
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .io0_in(io0_in),
    .io4_in(io4_in),
    .frame_out(frm)
  );

  logic frame_end;
  logic [rwc_pkg::LANES-1:0][rwc_pkg::SHIFT_W-1:0] al;
  logic [7:0] instr;
  logic is_write_enable_cmd;
  logic is_write_disable_cmd;
  logic is_clear_status_cmd;
  logic is_bank_access_cmd;
  logic is_wrr;
  logic busy_any;
  logic bank_wr;
  logic wrr_ok;
  logic upd_done;

  always_comb begin
    nxt = r;
    nxt.cs_meta = cs_n_in;
    nxt.cs_sync = r.cs_meta;
    nxt.cs_prev = r.cs_sync;
    nxt.wp_meta = wp_n_in;
    nxt.wp_sync = r.wp_meta;
    // frame words are static once chip select has risen and synced
    frame_end = r.cs_sync && !r.cs_prev;
    for (int l = 0; l < rwc_pkg::LANES; l++) begin
      al[l] = align_frame(frm.shift[l], frm.bits);
    end
    instr = al[0][23:16];
    busy_any = r.busy || embedded_busy_in;
    is_write_enable_cmd = frame_end && frm.bits == rwc_pkg::BITS_INSTR
      && instr == rwc_pkg::CMD_WRITE_EN;
    is_write_disable_cmd = frame_end && frm.bits == rwc_pkg::BITS_INSTR
      && instr == rwc_pkg::CMD_WRITE_DIS;
    is_clear_status_cmd = frame_end && frm.bits == rwc_pkg::BITS_INSTR
      && instr == rwc_pkg::CMD_CLEAR_STATUS;
    is_bank_access_cmd = frame_end && frm.bits == rwc_pkg::BITS_INSTR
      && instr == rwc_pkg::CMD_BANK_ACCESS;
    is_wrr = frame_end && instr == rwc_pkg::CMD_WRITE_REGS
      && (frm.bits == rwc_pkg::BITS_ONE || frm.bits == rwc_pkg::BITS_TWO);
    bank_wr = is_wrr && r.armed;
    // quad mode rejects the short format rather than guess at the config byte
    wrr_ok = is_wrr && !r.armed && !busy_any
      && r.sr1[0][rwc_pkg::SR1_WEL]
      && !(r.sr1[0][rwc_pkg::SR1_STATUS_WRITE_PROTECT] && !r.wp_sync)
      && !(r.cr[0][rwc_pkg::CR_QUAD] && frm.bits == rwc_pkg::BITS_ONE);
    upd_done = r.busy && r.cnt == 16'h0001;

    // any closed frame ends bank access; only an exact one opens it
    if (frame_end) begin
      nxt.armed = is_bank_access_cmd;
    end

    // self-timed update
    if (wrr_ok) begin
      nxt.busy = 1'b1;
      nxt.cnt = UPD_LOAD;
    end else if (r.busy) begin
      nxt.cnt = r.cnt - 16'h0001;
      if (upd_done) begin
        nxt.busy = 1'b0;
      end
    end

    for (int l = 0; l < rwc_pkg::LANES; l++) begin
      if (is_write_enable_cmd) begin
        nxt.sr1[l][rwc_pkg::SR1_WEL] = 1'b1;
      end
      if (is_write_disable_cmd && !busy_any) begin
        nxt.sr1[l][rwc_pkg::SR1_WEL] = 1'b0;
      end
      // latch untouched, accepted even while busy
      if (is_clear_status_cmd) begin
        nxt.sr1[l][rwc_pkg::SR1_E_FAIL] = 1'b0;
        nxt.sr1[l][rwc_pkg::SR1_P_FAIL] = 1'b0;
      end
      if (bank_wr) begin
        nxt.bank[l][rwc_pkg::BANK_LO_W-1:0] = al[l][9:8];
      end
      if (wrr_ok) begin
        nxt.sr1[l] = (r.sr1[l] & ~rwc_pkg::SR1_WR_MASK)
          | (al[l][15:8] & rwc_pkg::SR1_WR_MASK);
        if (frm.bits == rwc_pkg::BITS_TWO) begin
          nxt.cr[l] = al[l][7:0];
        end
      end
      // fail set applied after the clear so that it wins
      if (upd_done) begin
        nxt.sr1[l][rwc_pkg::SR1_WEL] = 1'b0;
        if (update_fail_in[0]) begin
          nxt.sr1[l][rwc_pkg::SR1_P_FAIL] = 1'b1;
        end
        if (update_fail_in[1]) begin
          nxt.sr1[l][rwc_pkg::SR1_E_FAIL] = 1'b1;
        end
      end
      // a set fail flag keeps the WIP status bit set until cleared
      nxt.sr1[l][rwc_pkg::SR1_WIP] = nxt.busy || embedded_busy_in
        || nxt.sr1[l][rwc_pkg::SR1_E_FAIL] || nxt.sr1[l][rwc_pkg::SR1_P_FAIL];
      nxt.addr_hi[l] = nxt.bank[l][rwc_pkg::BANK_EXT] ? '0
        : nxt.bank[l][rwc_pkg::BANK_LO_W-1:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      r <= CORE_RST;
    end else begin
      r <= nxt;
    end
  end

  assign sr1_out = r.sr1;
  assign cr_out = r.cr;
  assign bank_out = r.bank;
  assign addr_hi_out = r.addr_hi;
  assign update_busy_out = r.busy;
  assign bank_armed_out = r.armed;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);

  sequence wrr_start_s;
    wrr_ok && !upd_done;
  endsequence

  sequence update_run_s;
    r.busy [*8];
  endsequence

  sequence bank_pair_s;
    r.armed ##0 frame_end ##0 is_wrr;
  endsequence

  wel_set_a: assert property (is_write_enable_cmd && !upd_done |=> r.sr1[0][1])
    else $error("write enable did not set the latch");

  write_disable_cmd_clear_a: assert property (is_write_disable_cmd && !busy_any && !is_write_enable_cmd
    |=> !r.sr1[0][1] && !r.sr1[1][1])
    else $error("write disable did not clear the latch");

  write_disable_cmd_busy_a: assert property (is_write_disable_cmd && busy_any && !upd_done
    |=> $stable(r.sr1[0][1]))
    else $error("write disable acted while busy");

  clear_status_cmd_fail_a: assert property (is_clear_status_cmd && !upd_done
    |=> !r.sr1[0][5] && !r.sr1[0][6] && $stable(r.sr1[0][1]))
    else $error("clear status left a fail flag or moved the latch");

  wrr_gate_a: assert property (is_wrr && !r.armed && !r.sr1[0][1]
    |=> !$rose(r.busy) ##0 $stable(r.cr))
    else $error("write registers ran without the latch");

  wrr_len_a: assert property (frame_end && instr == 8'h01
    && frm.bits != 5'h10 && frm.bits != 5'h18 |=> !$rose(r.busy))
    else $error("write registers ran on a bad frame length");

  update_run_a: assert property (wrr_start_s |=> update_run_s)
    else $error("register update ended too early");

  update_end_a: assert property ($fell(r.busy) |-> !r.sr1[0][1] && !r.sr1[1][1])
    else $error("latch still set after the update");

  wip_shown_a: assert property (r.busy |-> r.sr1[0][0] && r.sr1[1][0])
    else $error("busy update not shown in status");

  bank_load_a: assert property (bank_pair_s
    |=> r.bank[0][1:0] == $past(al[0][9:8]) && $stable(r.bank[0][7])
    && !r.armed && !r.busy)
    else $error("bank access write went astray");

  bank_close_a: assert property (r.armed && frame_end && !is_bank_access_cmd |=> !r.armed)
    else $error("bank access stayed open");

  arm_exact_a: assert property (frame_end && frm.bits != 5'h08 |=> !r.armed)
    else $error("bank access armed on a bad frame");

  fail_set_a: assert property (upd_done && update_fail_in[0] |=> r.sr1[0][6])
    else $error("failed update did not set the program fail flag");

  addr_hi_a: assert property (!r.bank[0][7] |-> r.addr_hi[0] == r.bank[0][1:0])
    else $error("high address bits do not follow the bank register");

  efail_set_a: assert property (upd_done && update_fail_in[1] |=> r.sr1[0][5])
    else $error("failed update did not set the erase fail flag");

  wp_block_a: assert property (is_wrr && !r.armed && r.sr1[0][7] && !r.wp_sync
    |=> !$rose(r.busy) && $stable(r.sr1[0][4:2]))
    else $error("write registers ran while protected");

  quad_short_a: assert property (is_wrr && !r.armed && r.cr[0][1] && frm.bits == 5'h10
    |=> !$rose(r.busy) && $stable(r.cr[0]))
    else $error("short write registers ran in quad mode");

  wrr_data_a: assert property (wrr_ok |=> r.sr1[0][4:2] == $past(al[0][12:10]))
    else $error("block protect bits not loaded");

endmodule : rwc_core

`default_nettype wire

// >>> verilog/rwc_link_rx.sv
`default_nettype none

module rwc_link_rx (
  // serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic io0_in,
  input wire logic io4_in,
  // captured frame, static while chip select is high
  output var rwc_pkg::rwc_frame_s frame_out
);

  typedef struct packed {
    rwc_pkg::rwc_frame_s frm;
  } rwc_link_s;

  rwc_link_s r;
  rwc_link_s nxt;
  logic open_r;

  // armed by chip select high; sck stands still outside frames,
  // so the frame start cannot be seen by an sck edge
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      open_r <= 1'b0;
    end else begin
      open_r <= 1'b1;
    end
  end

  always_comb begin
    nxt = r;
    if (!open_r) begin
      nxt.frm.bits = 5'h01;
      nxt.frm.shift[0] = {{(rwc_pkg::SHIFT_W-1){1'b0}}, io0_in};
      nxt.frm.shift[1] = {{(rwc_pkg::SHIFT_W-1){1'b0}}, io4_in};
    end else begin
      if (r.frm.bits != rwc_pkg::BITS_MAX) begin
        nxt.frm.bits = r.frm.bits + 5'h01;
      end
      nxt.frm.shift[0] = {r.frm.shift[0][rwc_pkg::SHIFT_W-2:0], io0_in};
      nxt.frm.shift[1] = {r.frm.shift[1][rwc_pkg::SHIFT_W-2:0], io4_in};
    end
  end

  // no reset: the core only reads this after a frame has closed
  always_ff @(posedge sck_in) begin
    r <= nxt;
  end

  assign frame_out = r.frm;

endmodule : rwc_link_rx

`default_nettype wire

// >>> verilog/rwc_pkg.sv
`default_nettype none

package rwc_pkg;

  // command codes
  localparam logic [7:0] CMD_BANK_ACCESS = 8'hB9;
  localparam logic [7:0] CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] CMD_WRITE_EN = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;

  // status register one field positions
  localparam int SR1_WIP = 0;
  localparam int SR1_WEL = 1;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_BP_MID = 3;
  localparam int SR1_BP_HI = 4;
  localparam int SR1_E_FAIL = 5;
  localparam int SR1_P_FAIL = 6;
  localparam int SR1_STATUS_WRITE_PROTECT = 7;
  // bits that a write registers command may change
  localparam logic [7:0] SR1_WR_MASK = 8'h9C;

  // configuration and bank register field positions
  localparam int CR_QUAD = 1;
  localparam int BANK_EXT = 7;
  localparam int BANK_LO_W = 2;

  // reset values
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] CR_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;

  // frame geometry
  localparam int LANES = 2;
  localparam int SHIFT_W = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_INSTR = 5'h08;
  localparam logic [CNT_W-1:0] BITS_ONE = 5'h10;
  localparam logic [CNT_W-1:0] BITS_TWO = 5'h18;
  localparam logic [CNT_W-1:0] BITS_MAX = 5'h1F;

  // self-timed register update
  localparam int CLK_PERIOD_NS = 4;
  localparam int UPDATE_TIME_NS = 64;
  localparam int UPDATE_CYCLES = (UPDATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 16;

  typedef struct packed {
    logic [CNT_W-1:0] bits;
    logic [LANES-1:0][SHIFT_W-1:0] shift;
  } rwc_frame_s;

endpackage : rwc_pkg

`default_nettype wire
